/* design/dtmc_core.sv */
// measurement sequencer and limit checker of a two-channel thermometer
// assumes a front end that offers one sample code per converter clock edge
// and a host that reaches the registers over a plain one-cycle port
//
// Contract
// - in normal operation conversions run back to back with no request
// - successive conversions alternate between local and remote sensor
// - each result is stored as an 8-bit twos complement value
// - each result is checked against its high and low limits into flags
// - any set limit flag pulls the interrupt output low
// - host writes limits and configuration and reads every register
// - both value registers hold minus 128 after reset
// - first comparison only after both a local and remote result stored
// - powered up in standby, the defaults are compared, setting low flags
// - or leave standby and read status; clears only when in limits
// - each stored result averages 16 measurement cycles
// - one degree per step, results never below zero, up to 127
// - the mask bit suppresses current and later alerts
// - upper nibble of the die revision register is a part code
// - standby pin high runs conversions, low selects standby
// - interrupt output is open drain and active low
// - status read clears flags only whose cause has gone
// - status bits 6 to 3 are local high, local low, remote high, low
`timescale 1ns/10ps
module dtmc_core
    import dtmc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdData,
    // pins
    input wire logic standbySelectPin,
    input wire logic adcClkPin,
    input wire logic [7:0] sampleCode,
    input wire logic openSensorPin,
    output logic alertOut,
    output logic alertOe,
    // front end control
    output logic chanSel,
    output logic convActive
);

    function automatic logic sgt(input logic [7:0] a, input logic [7:0] b);
        return $signed(a) > $signed(b);
    endfunction : sgt

    function automatic logic slt(input logic [7:0] a, input logic [7:0] b);
        return $signed(a) < $signed(b);
    endfunction : slt

    // pin synchronisers: stage one feeds stage two only
    logic stby1_q, stby2_q, open1_q, open2_q, adc1_q, adc2_q, adc3_q;
    logic [7:0] samp1_q, samp2_q;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            stby1_q <= 1'b0;
            stby2_q <= 1'b0;
            open1_q <= 1'b0;
            open2_q <= 1'b0;
            adc1_q <= 1'b0;
            adc2_q <= 1'b0;
            adc3_q <= 1'b0;
            samp1_q <= 8'h00;
            samp2_q <= 8'h00;
        end
        else
        begin
            stby1_q <= standbySelectPin;
            stby2_q <= stby1_q;
            open1_q <= openSensorPin;
            open2_q <= open1_q;
            adc1_q <= adcClkPin;
            adc2_q <= adc1_q;
            adc3_q <= adc2_q;
            samp1_q <= sampleCode;
            samp2_q <= samp1_q;
        end
    end

    logic adcTick;
    assign adcTick = adc2_q & ~adc3_q;

    // registers written by the host
    logic [7:0] cfg_q, rate_q, lHi_q, lLo_q, rHi_q, rLo_q;
    logic wrHit;
    assign wrHit = regWr;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cfg_q <= DTMC_CFG_RST;
            rate_q <= DTMC_RATE_RST;
            lHi_q <= DTMC_HI_RST;
            lLo_q <= DTMC_LO_RST;
            rHi_q <= DTMC_HI_RST;
            rLo_q <= DTMC_LO_RST;
        end
        else if (wrHit)
        begin
            case (regAddr)
                DTMC_WR_CONFIG: cfg_q <= regWrData & DTMC_CFG_USED;
                DTMC_WR_RATE: rate_q <= regWrData & DTMC_RATE_USED;
                DTMC_WR_LHI: lHi_q <= regWrData;
                DTMC_WR_LLO: lLo_q <= regWrData;
                DTMC_WR_RHI: rHi_q <= regWrData;
                DTMC_WR_RLO: rLo_q <= regWrData;
                default: ;
            endcase
        end
    end

    // run control: pin low or config standby bit stops the converter
    logic runMode, oneShot_q, running;
    assign runMode = stby2_q & ~cfg_q[DTMC_CFG_STANDBY_SELECT_PIN_BIT];
    assign running = runMode | oneShot_q;

    // sequencer
    dtmc_state_t state_q;
    logic [3:0] avgCnt_q;
    logic [DTMC_ACC_W-1:0] acc_q;
    logic [DTMC_ACC_W-1:0] accNext;
    logic [7:0] clampCode, avgCode;
    logic lastTick, storeLocal, storeRemote;

    // negative codes are floored at zero before averaging
    assign clampCode = samp2_q[7] ? 8'h00 : samp2_q;
    assign accNext = acc_q + {{(DTMC_ACC_W-8){1'b0}}, clampCode};
    assign avgCode = accNext[DTMC_AVG_SHIFT +: 8];
    assign lastTick = adcTick && (avgCnt_q == DTMC_AVG_LAST);
    assign storeLocal = lastTick && running && (state_q == DTMC_LOCAL);
    assign storeRemote = lastTick && running && (state_q == DTMC_REMOTE);

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_q <= DTMC_STOP;
            avgCnt_q <= 4'h0;
            acc_q <= '0;
            chanSel <= 1'b0;
        end
        else
        begin
            case (state_q)
                DTMC_STOP:
                begin
                    avgCnt_q <= 4'h0;
                    acc_q <= '0;
                    chanSel <= 1'b0;
                    if (running)
                    begin
                        state_q <= DTMC_LOCAL;
                    end
                end
                DTMC_LOCAL, DTMC_REMOTE:
                begin
                    // a partial average is dropped when standby hits
                    if (!running)
                    begin
                        state_q <= DTMC_STOP;
                    end
                    else if (adcTick)
                    begin
                        avgCnt_q <= avgCnt_q + 4'h1;
                        acc_q <= lastTick ? '0 : accNext;
                        if (lastTick && state_q == DTMC_LOCAL)
                        begin
                            state_q <= DTMC_REMOTE;
                            chanSel <= 1'b1;
                        end
                        else if (lastTick)
                        begin
                            // next pass starts at once when free running
                            state_q <= runMode ? DTMC_LOCAL : DTMC_STOP;
                            chanSel <= 1'b0;
                        end
                    end
                end
                default: state_q <= DTMC_STOP;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            convActive <= 1'b0;
        end
        else
        begin
            convActive <= running && (state_q != DTMC_STOP);
        end
    end

    // one-shot: a single local and remote pass while stopped
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            oneShot_q <= 1'b0;
        end
        else if (regWr && regAddr == DTMC_WR_ONESHOT && !runMode)
        begin
            oneShot_q <= 1'b1;
        end
        else if (storeRemote || runMode)
        begin
            oneShot_q <= 1'b0;
        end
    end

    // value registers
    logic [7:0] localVal_q, remoteVal_q;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            localVal_q <= DTMC_VAL_RST;
            remoteVal_q <= DTMC_VAL_RST;
        end
        else
        begin
            if (storeLocal)
            begin
                localVal_q <= avgCode;
            end
            if (storeRemote)
            begin
                remoteVal_q <= avgCode;
            end
        end
    end

    // startup: wait for the pin synchronisers, then one check in standby
    logic [1:0] startCnt_q;
    logic bothSeen_q, startupEval;
    assign startupEval = (startCnt_q == DTMC_START_WAIT - 2'h1) && !runMode;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            startCnt_q <= 2'h0;
            bothSeen_q <= 1'b0;
        end
        else
        begin
            if (startCnt_q != DTMC_START_WAIT)
            begin
                startCnt_q <= startCnt_q + 2'h1;
            end
            if (storeRemote)
            begin
                bothSeen_q <= 1'b1;
            end
        end
    end

    // comparisons
    logic evalLocal, evalRemote;
    logic [7:0] evLocalVal, evRemoteVal;
    dtmc_flags_t setF, condF, flags_q;

    assign evalLocal = startupEval
        | (storeLocal & bothSeen_q)
        | (storeRemote & ~bothSeen_q);
    assign evalRemote = startupEval | storeRemote;
    assign evLocalVal = storeLocal ? avgCode : localVal_q;
    assign evRemoteVal = storeRemote ? avgCode : remoteVal_q;

    always_comb
    begin
        setF = '0;
        if (evalLocal)
        begin
            setF.localOverMaxFlag = sgt(evLocalVal, lHi_q);
            setF.localUnderMinFlag = slt(evLocalVal, lLo_q);
        end
        if (evalRemote)
        begin
            setF.remoteOverMaxFlag = sgt(evRemoteVal, rHi_q);
            setF.remoteUnderMinFlag = slt(evRemoteVal, rLo_q);
            setF.openSensorFlag = storeRemote & open2_q;
        end
    end

    // live causes, judged against the limits as they stand now
    always_comb
    begin
        condF.localOverMaxFlag = sgt(localVal_q, lHi_q);
        condF.localUnderMinFlag = slt(localVal_q, lLo_q);
        condF.remoteOverMaxFlag = sgt(remoteVal_q, rHi_q);
        condF.remoteUnderMinFlag = slt(remoteVal_q, rLo_q);
        condF.openSensorFlag = open2_q;
    end

    logic statusRd;
    assign statusRd = regRd && (regAddr == DTMC_RD_STATUS);

    // a new trip in the read cycle survives the clear
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            flags_q <= '0;
        end
        else
        begin
            flags_q <= setF | (flags_q & ~({5{statusRd}} & ~condF));
        end
    end

    // alert pin: only ever pulled low, released otherwise
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            alertOut <= 1'b0;
            alertOe <= 1'b0;
        end
        else
        begin
            alertOut <= 1'b0;
            alertOe <= (|flags_q) & ~cfg_q[DTMC_CFG_MASK_BIT];
        end
    end

    // read port: data stands one cycle after the strobe, zero otherwise
    always_ff @(posedge clk)
    begin
        if (rst || !regRd)
        begin
            regRdData <= 8'h00;
        end
        else
        begin
            case (regAddr)
                DTMC_RD_LOCAL: regRdData <= localVal_q;
                DTMC_RD_REMOTE: regRdData <= remoteVal_q;
                DTMC_RD_STATUS: regRdData <= {convActive, flags_q, 2'b00};
                DTMC_RD_CONFIG: regRdData <= cfg_q;
                DTMC_RD_RATE: regRdData <= rate_q;
                DTMC_RD_LHI: regRdData <= lHi_q;
                DTMC_RD_LLO: regRdData <= lLo_q;
                DTMC_RD_RHI: regRdData <= rHi_q;
                DTMC_RD_RLO: regRdData <= rLo_q;
                DTMC_RD_MFR: regRdData <= DTMC_MFR_ID;
                DTMC_RD_REV: regRdData <= {DTMC_PART_ID, DTMC_DIE_REV};
                default: regRdData <= 8'h00;
            endcase
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_free_run_next: assert property (storeRemote && runMode |=> state_q == DTMC_LOCAL)
        else $error("free run did not restart local conversion");
    a_chan_alternate: assert property (storeLocal |=> chanSel ##0 state_q == DTMC_REMOTE)
        else $error("channel did not switch to remote");
    a_value_stored: assert property (storeLocal |=> localVal_q == $past(avgCode))
        else $error("local value not stored");
    a_cmp_remote_low: assert property (storeRemote && slt(avgCode, rLo_q) |=> flags_q.remoteUnderMinFlag)
        else $error("remote low trip not flagged");
    a_alert_follows: assert property ((|flags_q) && !cfg_q[DTMC_CFG_MASK_BIT] |=> alertOe)
        else $error("alert not asserted on flag");
    a_alert_masked: assert property (cfg_q[DTMC_CFG_MASK_BIT] |=> !alertOe)
        else $error("masked alert still driven");
    a_alert_drive_low: assert property (alertOe |-> !alertOut)
        else $error("alert driven high");
    a_values_at_reset: assert property (startCnt_q == 2'h0 |-> localVal_q == DTMC_VAL_RST && remoteVal_q == DTMC_VAL_RST)
        else $error("value registers not at reset code");
    a_first_no_cmp: assert property (storeLocal && !bothSeen_q |=> !(flags_q.localOverMaxFlag && !$past(flags_q.localOverMaxFlag)))
        else $error("compared before both results stored");
    a_startup_low: assert property (startupEval && slt(localVal_q, lLo_q) |=> flags_q.localUnderMinFlag)
        else $error("standby startup low flag missing");
    a_nonneg_store: assert property (storeRemote |=> !remoteVal_q[7])
        else $error("negative result stored");
    a_flag_sticky: assert property (flags_q.localUnderMinFlag && condF.localUnderMinFlag |=> flags_q.localUnderMinFlag)
        else $error("flag cleared while cause present");
    a_status_bits: assert property (statusRd |=> regRdData[6:2] == $past(flags_q))
        else $error("status bit order wrong");
    a_standby_hold: assert property (!running && state_q == DTMC_STOP |=> $stable(localVal_q) && $stable(remoteVal_q))
        else $error("values changed in standby");
    a_rev_code: assert property (regRd && regAddr == DTMC_RD_REV |=> regRdData[7:4] == DTMC_PART_ID)
        else $error("part code missing");

    c_remote_store: cover property (storeRemote && bothSeen_q);
    c_status_clear: cover property (statusRd ##1 flags_q == '0);
    c_one_shot: cover property (oneShot_q ##[1:1000] storeRemote);
    c_alert_on: cover property ($rose(alertOe));

endmodule : dtmc_core

/* design/dtmc_pkg.sv */
// constants, types and register map of the dual temperature monitor core
// assumes one 200 MHz clock and a plain register port with 8-bit addresses
package dtmc_pkg;

    // read addresses
    localparam logic [7:0] DTMC_RD_LOCAL = 8'h00;
    localparam logic [7:0] DTMC_RD_REMOTE = 8'h01;
    localparam logic [7:0] DTMC_RD_STATUS = 8'h02;
    localparam logic [7:0] DTMC_RD_CONFIG = 8'h03;
    localparam logic [7:0] DTMC_RD_RATE = 8'h04;
    localparam logic [7:0] DTMC_RD_LHI = 8'h05;
    localparam logic [7:0] DTMC_RD_LLO = 8'h06;
    localparam logic [7:0] DTMC_RD_RHI = 8'h07;
    localparam logic [7:0] DTMC_RD_RLO = 8'h08;
    localparam logic [7:0] DTMC_RD_MFR = 8'hFE;
    localparam logic [7:0] DTMC_RD_REV = 8'hFF;

    // write addresses
    localparam logic [7:0] DTMC_WR_CONFIG = 8'h09;
    localparam logic [7:0] DTMC_WR_RATE = 8'h0A;
    localparam logic [7:0] DTMC_WR_LHI = 8'h0B;
    localparam logic [7:0] DTMC_WR_LLO = 8'h0C;
    localparam logic [7:0] DTMC_WR_RHI = 8'h0D;
    localparam logic [7:0] DTMC_WR_RLO = 8'h0E;
    localparam logic [7:0] DTMC_WR_ONESHOT = 8'h0F;

    // values after reset
    localparam logic [7:0] DTMC_VAL_RST = 8'h80;
    localparam logic [7:0] DTMC_CFG_RST = 8'h00;
    localparam logic [7:0] DTMC_RATE_RST = 8'h02;
    localparam logic [7:0] DTMC_HI_RST = 8'h7F;
    localparam logic [7:0] DTMC_LO_RST = 8'hC9;

    // field positions
    localparam int unsigned DTMC_CFG_MASK_BIT = 7;
    localparam int unsigned DTMC_CFG_STANDBY_SELECT_PIN_BIT = 6;
    localparam logic [7:0] DTMC_CFG_USED = 8'hC0;
    localparam logic [7:0] DTMC_RATE_USED = 8'h07;

    // identity codes: values are arbitrary
    localparam logic [7:0] DTMC_MFR_ID = 8'h5A;
    localparam logic [3:0] DTMC_PART_ID = 4'hA;
    localparam logic [3:0] DTMC_DIE_REV = 4'h1;

    // averaging: 16 measurement cycles per stored result
    localparam logic [3:0] DTMC_AVG_LAST = 4'hF;
    localparam int unsigned DTMC_AVG_SHIFT = 4;
    localparam int unsigned DTMC_ACC_W = 12;
    localparam logic [1:0] DTMC_START_WAIT = 2'h3;

    // limit flags in status order, bit 6 down to bit 2
    typedef struct packed {
        logic localOverMaxFlag;
        logic localUnderMinFlag;
        logic remoteOverMaxFlag;
        logic remoteUnderMinFlag;
        logic openSensorFlag;
    } dtmc_flags_t;

    typedef enum logic [1:0] {
        DTMC_STOP,
        DTMC_LOCAL,
        DTMC_REMOTE
    } dtmc_state_t;

endpackage : dtmc_pkg

/* test/dtmc_sensor_model.sv */
// front end model: converter clock and sample codes of both sensors
// assumes the core samples codes on converter clock rising edges
`timescale 1ns/10ps
module dtmc_sensor_model
(
    // converter pins
    output logic adcClkPin,
    output logic [7:0] sampleCode,
    // channel and temperatures
    input wire logic chanSel,
    input wire logic [7:0] localTemp,
    input wire logic [7:0] remoteTemp
);
    logic [3:0] noiseStep;

    // the converter clock runs free, frames or not
    initial
    begin
        adcClkPin = 1'b0;
        sampleCode = 8'h00;
        noiseStep = 4'h0;
        forever #62.5 adcClkPin = ~adcClkPin;
    end

    // codes change on the falling edge so they are stable at the rising one;
    // any 16 samples in a row carry offsets 0..15, so their mean truncates to temp+7
    always @(negedge adcClkPin)
    begin
        sampleCode <= (chanSel ? remoteTemp : localTemp) + {4'h0, noiseStep};
        noiseStep <= noiseStep + 4'h1;
    end
endmodule : dtmc_sensor_model

/* test/tb_dual_temp_monitor_compare.sv */
// self-checking bench of the temperature monitor core
// assumes the sensor model drives the converter pins
`timescale 1ns/10ps
module tb_dual_temp_monitor_compare;
    import dtmc_pkg::*;
    logic clk, rst, regWr, regRd, standbySelectPin, openSensorPin;
    logic [7:0] regAddr, regWrData, regRdData, sampleCode, localTemp;
    logic [7:0] remoteTemp, d, e;
    logic adcClkPin, alertOut, alertOe, chanSel, convActive;
    int fails, numChecks;
    logic [7:0] rdAddr [11] = '{8'h00, 8'h01, 8'h03, 8'h04, 8'h05, 8'h06,
        8'h07, 8'h08, 8'hFE, 8'h20, 8'h09};
    logic [7:0] rdExp [11] = '{8'h80, 8'h80, 8'h00, 8'h02, 8'h7F, 8'hC9,
        8'h7F, 8'hC9, DTMC_MFR_ID, 8'h00, 8'h00};

    dtmc_core u_dtmc_core (.clk(clk), .rst(rst), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .standbySelectPin(standbySelectPin),
        .adcClkPin(adcClkPin), .sampleCode(sampleCode),
        .openSensorPin(openSensorPin), .alertOut(alertOut),
        .alertOe(alertOe), .chanSel(chanSel), .convActive(convActive));

    dtmc_sensor_model u_dtmc_sensor_model (.adcClkPin(adcClkPin),
        .sampleCode(sampleCode), .chanSel(chanSel), .localTemp(localTemp),
        .remoteTemp(remoteTemp));

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic summarize;
        $display("checks %0d mismatches %0d", numChecks, fails);
        if (fails == 0 && numChecks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : summarize

    task automatic check(input string what, input logic [7:0] exp,
                         input logic [7:0] got);
        numChecks++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic regWrite(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= v;
        @(posedge clk);
        regWr <= 1'b0;
    endtask : regWrite

    // read data stand only in the cycle after the strobe
    task automatic regRead(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1 v = regRdData;
    endtask : regRead

    // polls a register until the masked value matches, bounded
    task automatic waitFor(input string what, input logic [7:0] a,
                           input logic [7:0] m, input logic [7:0] v);
        logic [7:0] r;
        for (int i = 0; i < 1500; i++)
        begin
            regRead(a, r);
            if ((r & m) === v)
            begin
                check(what, v, r & m);
                return;
            end
        end
        check(what, v, r & m);
        summarize();
    endtask : waitFor

    initial
    begin
        rst = 1'b1;
        regAddr = 8'h00;
        regWrData = 8'h00;
        regWr = 1'b0;
        regRd = 1'b0;
        standbySelectPin = 1'b0;
        openSensorPin = 1'b0;
        localTemp = 8'h19;
        remoteTemp = 8'h32;
        fails = 0;
        numChecks = 0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (8) @(posedge clk);
        for (int i = 0; i < 11; i++)
        begin
            regRead(rdAddr[i], d);
            check("reset register", rdExp[i], d);
        end
        regRead(DTMC_RD_REV, d);
        check("part code", {DTMC_PART_ID, 4'h0}, d & 8'hF0);
        regRead(DTMC_RD_STATUS, d);
        check("standby status", 8'h28, d);
        check("alert standby", 8'h01, {7'h0, alertOe});
        check("alert data", 8'h00, {7'h0, alertOut});
        repeat (500) @(posedge clk);
        regRead(DTMC_RD_LOCAL, d);
        check("local held", 8'h80, d);
        regWrite(DTMC_WR_LLO, 8'h80);
        regWrite(DTMC_WR_RLO, 8'h80);
        regRead(DTMC_RD_STATUS, d);
        regRead(DTMC_RD_STATUS, d);
        check("status cleared", 8'h00, d);
        repeat (3) @(posedge clk);
        check("alert cleared", 8'h00, {7'h0, alertOe});
        $display("test startup done");

        standbySelectPin <= 1'b1;
        waitFor("busy", DTMC_RD_STATUS, 8'h80, 8'h80);
        waitFor("remote value", DTMC_RD_REMOTE, 8'hFF, 8'h39);
        regRead(DTMC_RD_LOCAL, d);
        check("local value", localTemp + 8'h07, d);
        $display("test conversion done");

        regWrite(DTMC_WR_LHI, 8'h10);
        waitFor("local high", DTMC_RD_STATUS, 8'h7C, 8'h40);
        check("alert high", 8'h01, {7'h0, alertOe});
        regWrite(DTMC_WR_CONFIG, 8'h80);
        repeat (3) @(posedge clk);
        check("alert masked", 8'h00, {7'h0, alertOe});
        regRead(DTMC_RD_CONFIG, d);
        check("config", 8'h80, d);
        regWrite(DTMC_WR_RATE, 8'hFF);
        regRead(DTMC_RD_RATE, d);
        check("rate", 8'h07, d);
        regWrite(DTMC_WR_CONFIG, 8'h00);
        repeat (3) @(posedge clk);
        check("alert unmasked", 8'h01, {7'h0, alertOe});
        regRead(DTMC_RD_STATUS, d);
        regRead(DTMC_RD_STATUS, d);
        check("flag kept", 8'h40, d & 8'h7C);
        regWrite(DTMC_WR_LHI, 8'h7F);
        regRead(DTMC_RD_STATUS, d);
        regRead(DTMC_RD_STATUS, d);
        check("flag cleared", 8'h00, d & 8'h7C);
        $display("test limits done");

        remoteTemp <= 8'hEC;
        openSensorPin <= 1'b1;
        waitFor("open flag", DTMC_RD_STATUS, 8'h04, 8'h04);
        waitFor("floored", DTMC_RD_REMOTE, 8'hFF, 8'h00);
        regWrite(DTMC_WR_RLO, 8'h05);
        waitFor("remote low", DTMC_RD_STATUS, 8'h08, 8'h08);
        regWrite(DTMC_WR_RLO, 8'h80);
        openSensorPin <= 1'b0;
        repeat (10) @(posedge clk);
        regRead(DTMC_RD_STATUS, d);
        regRead(DTMC_RD_STATUS, d);
        check("open cleared", 8'h00, d & 8'h7C);
        $display("test sensor done");

        regWrite(DTMC_WR_CONFIG, 8'h40);
        // new temperatures long before the one-shot, so no stale sample
        localTemp <= 8'h2A;
        remoteTemp <= 8'h40;
        repeat (20) @(posedge clk);
        regRead(DTMC_RD_LOCAL, d);
        repeat (1000) @(posedge clk);
        regRead(DTMC_RD_LOCAL, e);
        check("standby value", d, e);
        check("standby idle", 8'h00, {7'h0, convActive});
        $display("test standby done");

        regWrite(DTMC_WR_ONESHOT, 8'h00);
        waitFor("one-shot remote", DTMC_RD_REMOTE, 8'hFF, 8'h47);
        regRead(DTMC_RD_LOCAL, d);
        check("one-shot local", 8'h31, d);
        regRead(DTMC_RD_STATUS, d);
        check("one-shot idle", 8'h00, d & 8'hFC);
        $display("test one-shot done");
        summarize();
    end
endmodule : tb_dual_temp_monitor_compare
